// [csoc_pkg.sv]
// constants, register map and enumerations for the clean switch output controller
// assumes one 100 MHz clock; reference and source status arrive already measured
package csoc_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int N_IN      = 16;
  localparam int N_CLEAN   = 2;
  localparam int N_AUX     = 6;
  localparam int N_OUT     = N_CLEAN + N_AUX;
  localparam int ADDR_W    = 8;
  localparam int LINE_WIN  = 3;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CH0     = 8'h08;
  localparam logic [7:0] OFS_CH1     = 8'h0C;
  localparam logic [7:0] OFS_AUX0    = 8'h10;
  localparam logic [7:0] OFS_AUX_END = 8'h24;

  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_RATE_LSB = 8;
  localparam logic [1:0] RST_TYPE   = 2'h1;
  localparam logic [7:0] RST_RATE   = 8'h1E;
  localparam logic [3:0] RST_FMTPOS = 4'h0;
  localparam logic [3:0] FMT_LAST   = 4'hD;
  localparam logic [1:0] TYPE_CUT   = 2'h0;

  localparam int ST_FMT_LSB = 0;
  localparam int ST_VALID   = 4;
  localparam int ST_REF     = 5;
  localparam int ST_BYP_LSB = 6;
  localparam int ST_BSY_LSB = 8;
  localparam int ST_STD_LSB = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // video standards seen on the reference and on the sources
  // ************************************************************
  typedef enum logic [4:0] {
    S_1080I_5994 = 5'h00, S_1080I_60   = 5'h01, S_1080P_2997 = 5'h02, S_1080P_30   = 5'h03,
    S_1080F_2997 = 5'h04, S_1080F_30   = 5'h05, S_1080I_50   = 5'h06, S_1080P_25   = 5'h07,
    S_1080F_25   = 5'h08, S_525I       = 5'h09, S_625I       = 5'h0A, S_720P_5994  = 5'h0B,
    S_720P_60    = 5'h0C, S_720P_50    = 5'h0D, S_1080P_5994 = 5'h0E, S_1080P_60   = 5'h0F,
    S_1080P_50   = 5'h10, S_D1080_5994 = 5'h11, S_D1080_60   = 5'h12, S_D1080_50   = 5'h13,
    S_720P_2997  = 5'h14, S_720P_30    = 5'h15, S_720P_25    = 5'h16, S_720P_2398  = 5'h17,
    S_720P_24    = 5'h18, S_1080P_2398 = 5'h19, S_1080P_24   = 5'h1A, S_1080F_2398 = 5'h1B,
    S_1080F_24   = 5'h1C, S_D720       = 5'h1D, S_UNK1       = 5'h1E, S_UNK2       = 5'h1F
  } csoc_std_t;

  // ************************************************************
  // clean channel states
  // ************************************************************
  typedef enum logic [2:0] {
    CH_IDLE = 3'b000,
    CH_WAIT = 3'b001,
    CH_MIX  = 3'b010,
    CH_BYP  = 3'b011,
    CH_FILL = 3'b100
  } csoc_ch_st_t;

endpackage

// [csoc_top.sv]
// clean switch output controller: crosspoint, mixer and bypass control with AXI4-Lite registers
// assumes reference, switchpoint and frame pulses and per-input status synchronous to aclk
module csoc_top
  import csoc_pkg::*;
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [csoc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [csoc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic [3:0]                   fmt_switch,
  input  wire logic                         ref_present,
  input  wire logic [4:0]                   ref_std,
  input  wire logic                         ref_switchpoint,
  input  wire logic                         ref_frame,
  input  wire logic [5*csoc_pkg::N_IN-1:0]  src_std,
  input  wire logic [csoc_pkg::N_IN-1:0]    src_rate_ok,
  input  wire logic [4*csoc_pkg::N_IN-1:0]  src_line_off,
  input  wire logic                         power_ok,
  output logic [csoc_pkg::N_IN-1:0]         xp1_to_mixer,
  output logic [4*csoc_pkg::N_OUT-1:0]      xp2_src,
  output logic [7:0]                        mix_prev_src,
  output logic [7:0]                        mix_next_src,
  output logic [1:0]                        mix_active,
  output logic [15:0]                       mix_frame,
  output logic [7:0]                        mix_len,
  output logic [1:0]                        mix_type,
  output logic [1:0]                        video_mix,
  output logic [1:0]                        audio_mix_a,
  output logic [1:0]                        audio_mix_b,
  output logic [1:0]                        clean_processed,
  output logic [1:0]                        bypass_sel,
  output logic [3:0]                        fmt_pos,
  output logic                              fmt_valid,
  output logic                              fmt_level_a,
  output logic                              fmt_level_b
);

  import csoc_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    csoc_ch_st_t st;
    logic [3:0]  cur;
    logic [3:0]  nxt;
    logic        from_proc;
    logic [7:0]  frm;
  } csoc_ch_t;

  typedef struct packed {
    logic                        fmt_done;
    logic [3:0]                  fmt_pos;
    logic [1:0]                  ttype;
    logic [7:0]                  trate;
    csoc_ch_t [N_CLEAN-1:0]      ch;
    logic [N_AUX-1:0][3:0]       aux_cur;
    logic [N_AUX-1:0][3:0]       aux_nxt;
    logic [N_AUX-1:0]            aux_pend;
    logic [N_IN-1:0]             xp1;
    logic [1:0]                  byp_sel;
    logic                        aw_got;
    logic [ADDR_W-1:0]           aw_addr;
    logic                        w_got;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
  } csoc_state_t;

  csoc_state_t s_reg;
  csoc_state_t s_next;

  // ************************************************************
  // format decode
  // ************************************************************
  function automatic logic pos_accepts(input logic [3:0] pos, input logic [4:0] std);
    logic ok;
    ok = 1'b0;
    unique case (pos)
      4'h0: ok = std inside {S_1080I_5994, S_1080I_60, S_1080P_2997, S_1080P_30,
                             S_1080F_2997, S_1080F_30};
      4'h1: ok = std inside {S_1080I_50, S_1080P_25, S_1080F_25};
      4'h2: ok = (std == S_525I);
      4'h3: ok = (std == S_625I);
      4'h4: ok = std inside {S_720P_5994, S_720P_60};
      4'h5: ok = (std == S_720P_50);
      4'h6: ok = std inside {S_1080P_5994, S_1080P_60};
      4'h7: ok = (std == S_1080P_50);
      4'h8: ok = std inside {S_D1080_5994, S_D1080_60};
      4'h9: ok = (std == S_D1080_50);
      4'hA: ok = std inside {S_720P_2997, S_720P_30};
      4'hB: ok = (std == S_720P_25);
      4'hC: ok = std inside {S_720P_2398, S_720P_24};
      4'hD: ok = std inside {S_1080P_2398, S_1080P_24, S_1080F_2398, S_1080F_24};
      4'hE, 4'hF: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [4:0] pos_primary(input logic [3:0] pos);
    logic [4:0] std;
    std = S_1080I_5994;
    unique case (pos)
      4'h0: std = S_1080I_5994;
      4'h1: std = S_1080I_50;
      4'h2: std = S_525I;
      4'h3: std = S_625I;
      4'h4: std = S_720P_5994;
      4'h5: std = S_720P_50;
      4'h6: std = S_1080P_5994;
      4'h7: std = S_1080P_50;
      4'h8: std = S_D1080_5994;
      4'h9: std = S_D1080_50;
      4'hA: std = S_720P_2997;
      4'hB: std = S_720P_25;
      4'hC: std = S_720P_2398;
      4'hD: std = S_1080P_2398;
      4'hE, 4'hF: std = S_1080I_5994;
    endcase
    return std;
  endfunction

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a, output logic hit);
    hit = (a[1:0] == 2'h0) && (a <= OFS_AUX_END);
    return a[5:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic             fmt_ok;
  logic [4:0]       active_std;
  logic             level_b;
  logic [N_IN-1:0]  src_good;

  assign fmt_ok     = s_reg.fmt_done && (s_reg.fmt_pos <= FMT_LAST);
  assign active_std = ref_present ? ref_std : pos_primary(s_reg.fmt_pos);
  assign level_b    = (s_reg.fmt_pos == 4'h8) || (s_reg.fmt_pos == 4'h9);

  // ************************************************************
  // per-input eligibility for processed switching
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_src
      logic signed [3:0] off;
      logic [4:0]        std;
      assign off = src_line_off[4*gi +: 4];
      assign std = src_std[5*gi +: 5];
      assign src_good[gi] = ref_present && fmt_ok && src_rate_ok[gi]
                         && (std == active_std) && pos_accepts(s_reg.fmt_pos, std)
                         // both sides signed, else the window test turns unsigned
                         && (off >= -$signed(4'(LINE_WIN)))
                         && (off <= $signed(4'(LINE_WIN)));
    end
  endgenerate

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic             do_w;
    logic             w_hit;
    logic             r_hit;
    logic [3:0]       w_idx;
    logic [3:0]       r_idx;
    logic [ADDR_W-1:0] w_addr;
    logic [31:0]      w_val;
    logic [31:0]      rd;
    logic             pair_ok;
    logic             cmd;
    logic [3:0]       cmd_src;
    s_next  = s_reg;
    do_w    = 1'b0;
    w_hit   = 1'b0;
    r_hit   = 1'b0;
    w_idx   = 4'h0;
    r_idx   = 4'h0;
    w_addr  = '0;
    w_val   = 32'h0000_0000;
    rd      = 32'h0000_0000;
    pair_ok = 1'b0;
    cmd     = 1'b0;
    cmd_src = 4'h0;

    // format switch captured once, first cycle after reset release
    if (!s_reg.fmt_done) begin
      s_next.fmt_pos  = fmt_switch;
      s_next.fmt_done = 1'b1;
    end

    s_next.byp_sel = {N_CLEAN{~power_ok}};

    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    do_w   = s_next.aw_got && s_next.w_got && !s_reg.bvalid;
    w_addr = s_next.aw_addr;
    w_idx  = reg_index(w_addr, w_hit);
    if (do_w) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = (w_hit && w_addr != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end
    w_val = merge(32'h0000_0000, s_next.w_data, s_next.w_strb);

    if (do_w && w_hit && w_addr == OFS_CTRL) begin
      if (s_next.w_strb[0]) begin
        s_next.ttype = w_val[CTRL_TYPE_LSB +: 2];
      end
      if (s_next.w_strb[1]) begin
        s_next.trate = w_val[CTRL_RATE_LSB +: 8];
      end
    end

    // auxiliary outputs: plain switches, timed to the switchpoint when referenced
    for (int a = 0; a < N_AUX; a++) begin
      if (s_reg.aux_pend[a] && (ref_switchpoint || !ref_present)) begin
        s_next.aux_cur[a]  = s_reg.aux_nxt[a];
        s_next.aux_pend[a] = 1'b0;
      end
      if (do_w && w_hit && s_next.w_strb[0] && w_idx == 4'(a + 4)) begin
        if (ref_present) begin
          s_next.aux_nxt[a]  = w_val[3:0];
          s_next.aux_pend[a] = 1'b1;
        end else begin
          s_next.aux_cur[a]  = w_val[3:0];
          s_next.aux_pend[a] = 1'b0;
        end
      end
    end

    // clean channels
    for (int c = 0; c < N_CLEAN; c++) begin
      pair_ok = src_good[s_reg.ch[c].cur] && src_good[s_reg.ch[c].nxt]
             && (src_std[5*s_reg.ch[c].cur +: 5] == src_std[5*s_reg.ch[c].nxt +: 5]);
      cmd     = do_w && w_hit && s_next.w_strb[0] && (w_idx == 4'(c + 2));
      cmd_src = w_val[3:0];
      unique case (s_reg.ch[c].st)
        CH_IDLE: begin
          if (!src_good[s_reg.ch[c].cur]) begin
            s_next.ch[c].st = CH_BYP;
          end
        end
        CH_BYP: begin
          if (src_good[s_reg.ch[c].cur]) begin
            s_next.ch[c].st = CH_FILL;
          end
        end
        CH_FILL: begin
          if (!src_good[s_reg.ch[c].cur]) begin
            s_next.ch[c].st = CH_BYP;
          end else if (ref_frame) begin
            s_next.ch[c].st = CH_IDLE;
          end
        end
        CH_WAIT: begin
          if (!ref_present) begin
            s_next.ch[c].cur = s_reg.ch[c].nxt;
            s_next.ch[c].st  = CH_BYP;
          end else if (ref_switchpoint) begin
            s_next.ch[c].frm = 8'h00;
            if (pair_ok && s_reg.ch[c].from_proc && s_reg.ttype != TYPE_CUT
                && s_reg.trate != 8'h00) begin
              s_next.ch[c].st = CH_MIX;
            end else begin
              s_next.ch[c].cur = s_reg.ch[c].nxt;
              // a clean cut from processed or from a mix stays processed, otherwise bypass
              s_next.ch[c].st  = (pair_ok && s_reg.ch[c].from_proc) ? CH_IDLE : CH_BYP;
            end
          end
        end
        CH_MIX: begin
          if (!pair_ok) begin
            s_next.ch[c].cur = s_reg.ch[c].nxt;
            s_next.ch[c].st  = CH_BYP;
          end else if (ref_frame) begin
            s_next.ch[c].frm = 8'(s_reg.ch[c].frm + 8'h01);
            if (8'(s_reg.ch[c].frm + 8'h01) >= s_reg.trate) begin
              s_next.ch[c].cur = s_reg.ch[c].nxt;
              s_next.ch[c].st  = CH_IDLE;
            end
          end
        end
        default: begin
          s_next.ch[c].st = CH_BYP;
        end
      endcase
      if (cmd) begin
        // a new command during a mix lands the mix on its target first
        s_next.ch[c].cur = (s_reg.ch[c].st == CH_MIX) ? s_reg.ch[c].nxt : s_reg.ch[c].cur;
        s_next.ch[c].from_proc = (s_reg.ch[c].st == CH_IDLE) || (s_reg.ch[c].st == CH_MIX);
        s_next.ch[c].nxt = cmd_src;
        s_next.ch[c].frm = 8'h00;
        if (ref_present) begin
          s_next.ch[c].st = CH_WAIT;
        end else begin
          s_next.ch[c].cur = cmd_src;
          s_next.ch[c].st  = CH_BYP;
        end
      end
    end

    // first crosspoint: inputs feeding a processed channel go to the mixer
    s_next.xp1 = '0;
    for (int c = 0; c < N_CLEAN; c++) begin
      if (s_next.ch[c].st == CH_IDLE || s_next.ch[c].st == CH_MIX
          || s_next.ch[c].st == CH_FILL) begin
        s_next.xp1[s_next.ch[c].cur] = 1'b1;
        if (s_next.ch[c].st == CH_MIX) begin
          s_next.xp1[s_next.ch[c].nxt] = 1'b1;
        end
      end
    end

    // read channel
    r_idx = reg_index(s_axi_araddr, r_hit);
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      unique case (r_idx)
        4'h0: rd = {16'h0000, s_reg.trate, 6'h00, s_reg.ttype};
        4'h1: begin
          rd[ST_FMT_LSB +: 4] = s_reg.fmt_pos;
          rd[ST_VALID]        = fmt_ok;
          rd[ST_REF]          = ref_present;
          for (int c = 0; c < N_CLEAN; c++) begin
            rd[ST_BYP_LSB + c] = s_reg.ch[c].st == CH_BYP || s_reg.ch[c].st == CH_FILL;
            rd[ST_BSY_LSB + c] = s_reg.ch[c].st == CH_WAIT || s_reg.ch[c].st == CH_MIX;
          end
          rd[ST_STD_LSB +: 5] = active_std;
        end
        4'h2, 4'h3: rd[3:0] = s_reg.ch[r_idx[0]].cur;
        default: begin
          for (int a = 0; a < N_AUX; a++) begin
            if (r_idx == 4'(a + 4)) begin
              rd[3:0] = s_reg.aux_cur[a];
            end
          end
        end
      endcase
      s_next.rvalid = 1'b1;
      s_next.rdata  = r_hit ? rd : 32'h0000_0000;
      s_next.rresp  = r_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg         <= '0;
      s_reg.fmt_pos <= RST_FMTPOS;
      s_reg.ttype   <= RST_TYPE;
      s_reg.trate   <= RST_RATE;
      for (int c = 0; c < N_CLEAN; c++) begin
        s_reg.ch[c].st <= CH_BYP;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;

  assign xp1_to_mixer = s_reg.xp1;
  assign mix_len      = s_reg.trate;
  assign mix_type     = s_reg.ttype;
  assign bypass_sel   = s_reg.byp_sel;
  assign fmt_pos      = s_reg.fmt_pos;
  assign fmt_valid    = fmt_ok;
  assign fmt_level_a  = fmt_ok && (s_reg.fmt_pos == 4'h6 || s_reg.fmt_pos == 4'h7);
  assign fmt_level_b  = fmt_ok && level_b;

  generate
    for (gi = 0; gi < N_CLEAN; gi++) begin : g_ch
      logic mixing;
      assign mixing                = s_reg.ch[gi].st == CH_MIX;
      assign xp2_src[4*gi +: 4]    = s_reg.ch[gi].cur;
      assign mix_prev_src[4*gi +: 4] = s_reg.ch[gi].cur;
      assign mix_next_src[4*gi +: 4] = s_reg.ch[gi].nxt;
      assign mix_frame[8*gi +: 8]  = s_reg.ch[gi].frm;
      assign mix_active[gi]        = mixing;
      assign video_mix[gi]         = mixing;
      assign audio_mix_a[gi]       = mixing;
      assign audio_mix_b[gi]       = mixing && !level_b;
      assign clean_processed[gi]   = s_reg.ch[gi].st == CH_IDLE || mixing;
    end
    for (gi = 0; gi < N_AUX; gi++) begin : g_aux
      assign xp2_src[4*(gi + N_CLEAN) +: 4] = s_reg.aux_cur[gi];
    end
  endgenerate

endmodule

// [csoc_assertions.sv]
// concurrent checks on the clean switch output controller ports
// assumes binding onto csoc_top, one clock domain, sync active-low reset
module csoc_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        power_ok,
  input wire logic        ref_switchpoint,
  input wire logic [3:0]  fmt_pos,
  input wire logic        fmt_valid,
  input wire logic        fmt_level_a,
  input wire logic        fmt_level_b,
  input wire logic [1:0]  bypass_sel,
  input wire logic [1:0]  mix_active,
  input wire logic [1:0]  video_mix,
  input wire logic [1:0]  audio_mix_a,
  input wire logic [1:0]  audio_mix_b,
  input wire logic [15:0] mix_frame,
  input wire logic [7:0]  mix_len
);
  // ****
  // properties
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_PWR_OK: assert property (power_ok [*2] |-> bypass_sel == 2'b00)
    else $error("bypass taken with power good");
  AST_PWR_FAIL: assert property (!power_ok [*2] |-> bypass_sel == 2'b11)
    else $error("bypass missing on power fail");
  // switch is captured at the first edge after release, so skip two edges
  AST_FMT_HOLD: assert property ($past(aresetn, 2) |-> $stable(fmt_pos))
    else $error("format position moved");
  AST_FMT_VALID: assert property ($past(aresetn) |-> fmt_valid == (fmt_pos <= 4'hD))
    else $error("format validity wrong");
  AST_LEVEL_A: assert property ($past(aresetn) |-> fmt_level_a == (fmt_pos[3:1] == 3'h3))
    else $error("level a decode wrong");
  AST_LEVEL_B: assert property ($past(aresetn) |-> fmt_level_b == (fmt_pos[3:1] == 3'h4))
    else $error("level b decode wrong");
  AST_MIX_AV: assert property (mix_active == video_mix && mix_active == audio_mix_a)
    else $error("video and audio mix apart");
  AST_LINK_B: assert property (audio_mix_b == (mix_active & ~{2{fmt_level_b}}))
    else $error("link b audio mixed");
  AST_MIX_START: assert property ($rose(mix_active[0]) |-> $past(ref_switchpoint) || $past(ref_switchpoint, 2))
    else $error("mix began off switchpoint");
  AST_MIX_LEN: assert property (mix_active[0] |-> mix_frame[7:0] <= mix_len)
    else $error("mix ran past its rate");
endmodule

bind csoc_top csoc_assertions u_chk (.aclk, .aresetn, .power_ok, .ref_switchpoint, .fmt_pos,
  .fmt_valid, .fmt_level_a, .fmt_level_b, .bypass_sel, .mix_active, .video_mix, .audio_mix_a,
  .audio_mix_b, .mix_frame, .mix_len);

// [csoc_src_model.sv]
// reference and source status model standing in front of the controller
// assumes a 20-cycle frame; input 4 can be forced off rate
module csoc_src_model (
  input  wire logic  aclk,
  input  wire logic  ref_on,
  input  wire logic  rate_bad,
  output logic       ref_present,
  output logic [4:0] ref_std,
  output logic       ref_switchpoint,
  output logic       ref_frame,
  output logic [79:0] src_std,
  output logic [15:0] src_rate_ok,
  output logic [63:0] src_line_off
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // framing
  // ****
  logic [4:0] cnt = 5'h00;
  always @(posedge aclk) begin
    cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
  end
  // pulses stand still when the reference is pulled
  assign ref_present     = ref_on;
  assign ref_std         = csoc_pkg::S_1080I_5994;
  assign ref_switchpoint = ref_on && cnt == 5'h00;
  assign ref_frame       = ref_on && cnt == 5'h0A;
  assign src_std         = {16{ref_std}};
  assign src_rate_ok     = rate_bad ? 16'hFFEF : 16'hFFFF;
  assign src_line_off    = '0;
endmodule

// [csoc_tb_top.sv]
// self-checking bench for the clean switch output controller
// assumes csoc_top, the source model and the checker in the same compile
module csoc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import csoc_pkg::*;
  // ****
  // signals
  // ****
  logic aclk = 1'b0, aresetn = 1'b0, power_ok = 1'b1, ref_on = 1'b1, rate_bad = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF, fmt_switch = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ref_present;
  logic [1:0] s_axi_bresp, s_axi_rresp, mix_active, mix_type, video_mix, audio_mix_a;
  logic [1:0] audio_mix_b, clean_processed, bypass_sel;
  logic [31:0] s_axi_rdata, xp2_src;
  logic [15:0] xp1_to_mixer, mix_frame, src_rate_ok;
  logic [7:0] mix_prev_src, mix_next_src, mix_len;
  logic [3:0] fmt_pos;
  logic fmt_valid, fmt_level_a, fmt_level_b, ref_switchpoint, ref_frame;
  logic [4:0] ref_std;
  logic [79:0] src_std;
  logic [63:0] src_line_off;
  int bad_count = 0, num_checks = 0, cyc = 0;
  // switch position, then expected valid, level a, level b
  logic [6:0] rows [8] = '{7'h04, 7'h36, 7'h3E, 7'h45, 7'h4D, 7'h6C, 7'h70, 7'h78};
  csoc_top dut (.*);
  csoc_src_model src (.aclk, .ref_on, .rate_bad, .ref_present, .ref_std, .ref_switchpoint,
    .ref_frame, .src_std, .src_rate_ok, .src_line_off);
  always #5 aclk = ~aclk;
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // switch is only sampled after reset, so each position needs its own reset
  task automatic rst(input logic [3:0] sw);
    @(posedge aclk);
    aresetn <= 1'b0;
    fmt_switch <= sw;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  // handshakes judged mid-cycle, where they stand settled for the coming edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_take, w_take, b_take;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_take = 1'b0;
    while (!b_take) begin
      @(negedge aclk);
      aw_take = s_axi_awvalid && s_axi_awready;
      w_take = s_axi_wvalid && s_axi_wready;
      b_take = s_axi_bvalid;
      if (b_take) chk(s_axi_bresp, er);
      @(posedge aclk);
      if (aw_take) s_axi_awvalid <= 1'b0;
      if (w_take) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ar_take, r_take;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_take = 1'b0;
    while (!r_take) begin
      @(negedge aclk);
      ar_take = s_axi_arvalid && s_axi_arready;
      r_take = s_axi_rvalid;
      if (r_take) begin
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, er);
      end
      @(posedge aclk);
      if (ar_take) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end
  // ****
  // sequence
  // ****
  initial begin
    foreach (rows[i]) begin
      rst(rows[i][6:3]);
      chk(fmt_pos, rows[i][6:3]);
      chk({fmt_valid, fmt_level_a, fmt_level_b}, rows[i][2:0]);
    end
    rst(4'h0);
    fmt_switch <= 4'h5;
    repeat (50) @(posedge aclk);
    chk({fmt_pos, clean_processed}, 6'h03);
    wr(OFS_CTRL, 32'h0000_0201, RESP_OKAY);
    chk({mix_type, mix_len}, 10'h102);
    wr(OFS_CH0, 32'h0000_0003, RESP_OKAY);
    repeat (60) if (!mix_active[0]) @(negedge aclk);
    chk({mix_active[0], mix_prev_src[3:0], mix_next_src[3:0]}, 9'h103);
    chk({xp1_to_mixer[3], audio_mix_b[0]}, 2'b11);
    repeat (100) if (mix_active[0]) @(negedge aclk);
    repeat (2) @(posedge aclk);
    chk(xp2_src[3:0], 4'h3);
    rd(OFS_CH0, 32'h0000_0003, RESP_OKAY);
    rate_bad <= 1'b1;
    wr(OFS_CH0, 32'h0000_0004, RESP_OKAY);
    repeat (60) if (xp2_src[3:0] !== 4'h4) @(negedge aclk);
    chk({xp2_src[3:0], mix_active[0], clean_processed[0]}, 6'h10);
    @(posedge aclk);
    ref_on <= 1'b0;
    wr(OFS_CH1, 32'h0000_0005, RESP_OKAY);
    wr(OFS_AUX0, 32'h0000_0007, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(xp2_src[11:4], 8'h75);
    power_ok <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(bypass_sel, 2'b11);
    power_ok <= 1'b1;
    rd(8'h40, 32'h0000_0000, RESP_SLVERR);
    rd(OFS_STATUS, 32'h0000_00D0, RESP_OKAY);
    close_out();
  end
endmodule
